// [hw/sid_pkg.sv]
// Purpose: Constants for the slave identifier and identification register group
// Assumes: Registers reached by the serial interface decoder over a plain address/data port
// Notes:   Identification codes are arbitrary neutral values
`default_nettype none
package sid_pkg;
  localparam logic [7:0] SID_OFS_TRIG  = 8'h1c;
  localparam logic [7:0] SID_OFS_PART  = 8'h1d;
  localparam logic [7:0] SID_OFS_MAKER = 8'h1e;
  localparam logic [7:0] SID_OFS_SLAVE = 8'h1f;
  localparam logic [7:0] SID_TRIG_RST  = 8'h00;
  // Arbitrary part code, not a real product value
  localparam logic [7:0] SID_PART_RST  = 8'h5a;
  // Arbitrary ten-bit maker code, not a real vendor value
  localparam logic [9:0] SID_MAKER_CODE = 10'h2a5;
  // Stored slave identifier default; bit 0 has no defined reset level, taken as zero
  localparam logic [3:0] SID_SLAVE_RST = 4'h4;
  localparam logic [1:0] SID_SPARE_RST = 2'h0;
  localparam int SID_SPARE_POS = 6;
  localparam int SID_MHI_POS   = 4;
  localparam int SID_ID_POS    = 0;
endpackage : sid_pkg
`default_nettype wire

// [hw/sid_pin_sync.sv]
// Purpose: Two-flop synchroniser for the address select pin
// Assumes: Pin is asynchronous to clk
// Notes:   First flop is read only by the second
`default_nettype none
module sid_pin_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      pin_sync
);
  logic meta_r;
  // Two stages against metastability
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r   <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_r   <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule : sid_pin_sync
`default_nettype wire

// [hw/sid_regs.sv]
// Purpose: Identification, power mode trigger and slave identifier registers
// Assumes: Serial interface decoder gives one-cycle write/read strobes with address
// Notes:   Read data is registered, valid one cycle after the read strobe
`default_nettype none
module sid_regs (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [3:0] frame_slave_id,
  input  wire logic       addr_select_en,
  input  wire logic       engineering_mode,
  input  wire logic       first_general_pin,
  output logic [7:0]      reg_rdata,
  output logic            slave_match,
  output logic [3:0]      bus_slave_identifier,
  output logic [1:0]      power_state_select,
  output logic [5:0]      power_mode_trigger
);
  // Stored contents of the group
  logic [7:0] trig_r;
  logic [7:0] part_r;
  logic [3:0] sid_r;
  logic [1:0] spare_r;
  // Synchronised pin and the identifier seen by the bus
  logic       pin_s;
  logic [3:0] sid_eff;
  // Decoded write enables, one per writable register
  logic       wr_trig;
  logic       wr_part;
  logic       wr_slave;
  // Read data ahead of the output flop
  logic [7:0] rdata_nxt;

  // Pin is asynchronous; nothing reads it before the second flop
  sid_pin_sync u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin_in   (first_general_pin),
    .pin_sync (pin_s)
  );

  // Address compare shared by the write decode
  function automatic logic hit(
    input logic [7:0] a,
    input logic [7:0] ofs
  );
    hit = (a == ofs);
  endfunction : hit

  // Identifier register image: spare, maker high bits, identifier
  function automatic logic [7:0] slave_word(
    input logic [1:0] spare,
    input logic [3:0] id
  );
    slave_word                              = 8'h00;
    slave_word[sid_pkg::SID_SPARE_POS +: 2] = spare;
    slave_word[sid_pkg::SID_MHI_POS +: 2]   = sid_pkg::SID_MAKER_CODE[9:8];
    slave_word[sid_pkg::SID_ID_POS +: 4]    = id;
  endfunction : slave_word

  // Write enables; the maker code has none, so writes to it fall away
  assign wr_trig  = reg_wr && hit(reg_addr, sid_pkg::SID_OFS_TRIG);
  assign wr_part  = reg_wr && hit(reg_addr, sid_pkg::SID_OFS_PART);
  assign wr_slave = reg_wr && hit(reg_addr, sid_pkg::SID_OFS_SLAVE);

  // Trigger register only stores; the power mode function is not supported
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      trig_r <= sid_pkg::SID_TRIG_RST;
    end else if (wr_trig) begin
      trig_r <= reg_wdata;
    end
  end

  // Part code is writable, so software may overwrite it until the next reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      part_r <= sid_pkg::SID_PART_RST;
    end else if (wr_part) begin
      part_r <= reg_wdata;
    end
  end

  // Spare bits are plain storage, open in either configuration
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      spare_r <= sid_pkg::SID_SPARE_RST;
    end else if (wr_slave) begin
      spare_r <= reg_wdata[sid_pkg::SID_SPARE_POS +: 2];
    end
  end

  // Identifier opens to writes only in engineering configuration
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sid_r <= sid_pkg::SID_SLAVE_RST;
    end else if (wr_slave && engineering_mode) begin
      sid_r <= reg_wdata[sid_pkg::SID_ID_POS +: 4];
    end
  end

  // With addr_select_en set, bit 0 follows the synchronised pin; two cycles of lag buy a clean identifier
  assign sid_eff = {sid_r[3:1], addr_select_en ? pin_s : sid_r[0]};
  assign bus_slave_identifier = sid_eff;
  // Match is combinational so the frame decoder can answer in the same cycle
  assign slave_match = (frame_slave_id == sid_eff);
  // Mode and trigger fields leave the block but steer nothing inside it
  assign power_state_select = trig_r[7:6];
  assign power_mode_trigger = trig_r[5:0];

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      sid_pkg::SID_OFS_TRIG: begin
        rdata_nxt = trig_r;
      end
      sid_pkg::SID_OFS_PART: begin
        rdata_nxt = part_r;
      end
      sid_pkg::SID_OFS_MAKER: begin
        rdata_nxt = sid_pkg::SID_MAKER_CODE[7:0];
      end
      sid_pkg::SID_OFS_SLAVE: begin
        rdata_nxt = slave_word(spare_r, sid_eff);
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Read data registered and held until the next read strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Write strobe to the identifier register
  sequence slave_write_s;
    reg_wr && reg_addr == sid_pkg::SID_OFS_SLAVE;
  endsequence

  // Read strobe to the identifier register
  sequence slave_read_s;
    reg_rd && reg_addr == sid_pkg::SID_OFS_SLAVE;
  endsequence

  // Pin high at two edges with the option on, option still on at the third
  sequence pin_held_high_s;
    (addr_select_en && first_general_pin) [*2] ##1 addr_select_en;
  endsequence

  // Pin low at two edges with the option on, option still on at the third
  sequence pin_held_low_s;
    (addr_select_en && !first_general_pin) [*2] ##1 addr_select_en;
  endsequence

  // Storage and reset
  trig_store_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && reg_addr == sid_pkg::SID_OFS_TRIG |=> trig_r == $past(reg_wdata))
    else $error("trigger write lost");

  reset_def_a: assert property (@(posedge clk)
    !reset_n |=> trig_r == sid_pkg::SID_TRIG_RST && sid_r == sid_pkg::SID_SLAVE_RST
      && part_r == sid_pkg::SID_PART_RST && spare_r == sid_pkg::SID_SPARE_RST && reg_rdata == 8'h00)
    else $error("reset default wrong");

  // Identifier and frame match
  id_match_a: assert property (@(posedge clk) disable iff (!reset_n)
    !addr_select_en |-> slave_match == (frame_slave_id == sid_r))
    else $error("slave match wrong");

  slave_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    slave_read_s |=> reg_rdata[3:0] == $past(bus_slave_identifier))
    else $error("identifier read wrong");

  stored_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus_slave_identifier[3:1] == sid_r[3:1])
    else $error("upper identifier bits wrong");

  // Address select pin tracking, two flops of lag
  pin_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    addr_select_en [*3] |-> bus_slave_identifier[0] == $past(first_general_pin, 2))
    else $error("pin not followed");

  pin_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    pin_held_high_s |-> bus_slave_identifier[0])
    else $error("bit not set");

  pin_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    pin_held_low_s |-> !bus_slave_identifier[0])
    else $error("bit not cleared");

  // Configuration gating of the stored identifier
  prod_lock_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && !engineering_mode |=> sid_r == $past(sid_r))
    else $error("production write took");

  eng_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    slave_write_s ##0 engineering_mode |=> sid_r == $past(reg_wdata[3:0]))
    else $error("engineering write lost");

  // Maker code is fixed in both registers
  maker_fix_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && reg_addr == sid_pkg::SID_OFS_MAKER |=> reg_rdata == sid_pkg::SID_MAKER_CODE[7:0])
    else $error("maker code wrong");

  maker_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    slave_read_s |=> reg_rdata[5:4] == sid_pkg::SID_MAKER_CODE[9:8])
    else $error("maker high bits wrong");
endmodule : sid_regs
`default_nettype wire

// [testbench/sid_bus_master.sv]
// Purpose: Bus master model issuing register strobes
// Assumes: Strobes change at the falling edge
// Notes:   Released address and data lines show the inverse, never a stale value
`default_nettype none
module sid_bus_master (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One-cycle strobe, read data taken a cycle later
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(negedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    q = rdata;
  endtask : op
endmodule : sid_bus_master
`default_nettype wire

// [testbench/tb.sv]
// Purpose: Register and slave identifier checks
// Assumes: Inputs driven at the falling edge
// Notes:   Expected codes are the arbitrary package defaults
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       asel = 1'b0;
  logic       eng = 1'b0;
  logic       pin = 1'b0;
  logic [3:0] fid = 4'h0;
  logic       wr, rd, match;
  logic [7:0] addr, wdata, rdata, q;
  logic [3:0] sid;
  logic [1:0] pss;
  logic [5:0] pmt;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  always #20 clk = ~clk;
  sid_bus_master u_m (.clk(clk), .rdata(rdata), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
  sid_regs DUT (.clk(clk), .reset_n(reset_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .frame_slave_id(fid), .addr_select_en(asel), .engineering_mode(eng), .first_general_pin(pin),
    .reg_rdata(rdata), .slave_match(match), .bus_slave_identifier(sid), .power_state_select(pss),
    .power_mode_trigger(pmt));
  // Compare and reports
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_m.op(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask : rdchk
  // Register write; read data not looked at
  task automatic wrreg(input logic [7:0] a, input logic [7:0] d);
    u_m.op(1'b1, a, d, q);
  endtask : wrreg
  // Frame match and effective identifier
  task automatic idchk(input logic m, input logic [3:0] id);
    chk({3'h0, match, sid}, {3'h0, m, id});
  endtask : idchk
  // Identifier register image: spare, maker high bits, identifier
  function automatic logic [7:0] slave_exp(input logic [1:0] spare, input logic [3:0] id);
    slave_exp = {spare, sid_pkg::SID_MAKER_CODE[9:8], id};
  endfunction : slave_exp
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard, run needs far fewer cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    rdchk(sid_pkg::SID_OFS_TRIG, sid_pkg::SID_TRIG_RST);
    rdchk(sid_pkg::SID_OFS_PART, sid_pkg::SID_PART_RST);
    rdchk(sid_pkg::SID_OFS_MAKER, sid_pkg::SID_MAKER_CODE[7:0]);
    rdchk(sid_pkg::SID_OFS_SLAVE, slave_exp(sid_pkg::SID_SPARE_RST, sid_pkg::SID_SLAVE_RST));
    rdchk(8'h20, 8'h00); // Unmapped
    wrreg(sid_pkg::SID_OFS_TRIG, 8'h81);
    chk({pss, pmt}, 8'h81);
    rdchk(sid_pkg::SID_OFS_TRIG, 8'h81);
    wrreg(sid_pkg::SID_OFS_PART, 8'h3c);
    rdchk(sid_pkg::SID_OFS_PART, 8'h3c);
    wrreg(sid_pkg::SID_OFS_MAKER, 8'hff);
    wrreg(sid_pkg::SID_OFS_SLAVE, 8'hff);
    rdchk(sid_pkg::SID_OFS_MAKER, sid_pkg::SID_MAKER_CODE[7:0]);
    rdchk(sid_pkg::SID_OFS_SLAVE, slave_exp(2'h3, sid_pkg::SID_SLAVE_RST));
    eng = 1'b1;
    wrreg(sid_pkg::SID_OFS_SLAVE, 8'hca);
    fid = 4'ha;
    rdchk(sid_pkg::SID_OFS_SLAVE, slave_exp(2'h3, 4'ha));
    idchk(1'b1, 4'ha);
    // Pin option on; two synchroniser flops, so three cycles settle it
    asel = 1'b1;
    pin = 1'b1;
    repeat (3) @(negedge clk);
    idchk(1'b0, 4'hb);
    rdchk(sid_pkg::SID_OFS_SLAVE, slave_exp(2'h3, 4'hb));
    pin = 1'b0;
    repeat (3) @(negedge clk);
    idchk(1'b1, 4'ha);
    pin = 1'b1;
    repeat (3) @(negedge clk);
    idchk(1'b0, 4'hb);
    // Option off with the pin still high: stored bit shows again
    asel = 1'b0;
    @(negedge clk);
    idchk(1'b1, 4'ha);
    pin = 1'b0;
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    rdchk(sid_pkg::SID_OFS_TRIG, sid_pkg::SID_TRIG_RST);
    rdchk(sid_pkg::SID_OFS_PART, sid_pkg::SID_PART_RST);
    rdchk(sid_pkg::SID_OFS_SLAVE, slave_exp(sid_pkg::SID_SPARE_RST, sid_pkg::SID_SLAVE_RST));
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
